// File: umcd_regs.vh
`ifndef UMCD_REGS_VH
`define UMCD_REGS_VH

// ****************************************************************
// Miscellaneous command codes, upper nibble of a command write
// ****************************************************************
`define UMCD_CMD_HI 7
`define UMCD_CMD_LO 4
`define UMCD_CMD_BREAK_ON 4'h6
`define UMCD_CMD_BREAK_OFF 4'h7
`define UMCD_CMD_RTS_ASSERT 4'h8
`define UMCD_CMD_RTS_NEGATE 4'h9
`define UMCD_CMD_TMO_ON 4'hA
`define UMCD_CMD_PTR_ZERO 4'hB
`define UMCD_CMD_TMO_OFF 4'hC
`define UMCD_CMD_UNUSED 4'hD
`define UMCD_CMD_PD_ON 4'hE
`define UMCD_CMD_PD_OFF 4'hF

// ****************************************************************
// Reset values and timing
// ****************************************************************
`define UMCD_PTR_ZERO 2'h0
`define UMCD_PTR_RESET 2'h1
`define UMCD_BRK_DELAY_BITS 2
`define UMCD_MARK_HOLD_BITS 1
`define UMCD_CMD_GAP_EDGES 3

`endif

// File: umcd_sync.v
`timescale 1ns/1ns
// Two-stage synchroniser for one level from outside the clock domain
module umcd_sync (
    // Clock and reset
    input wire clk,
    input wire rstn,
    // Data
    input wire async_in,
    output reg sync_out
);

reg stage1;

always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
        stage1 <= 1'b0;
        sync_out <= 1'b0;
    end else begin
        stage1 <= async_in;
        sync_out <= stage1;
    end
end

endmodule // umcd_sync

// File: umcd_channel.v
`timescale 1ns/1ns
`include "umcd_regs.vh"
// One channel: break, request-to-send, time-out mode and pointer
module umcd_channel (
    // Clock and reset
    input wire clk,
    input wire rstn,
    // Command
    input wire cmd_valid,
    input wire [3:0] cmd_code,
    // Transmitter state
    input wire tx_enabled,
    input wire tx_idle,
    input wire bit_tick,
    input wire tx_char_out,
    // Results
    output reg break_active,
    output reg tx_hold,
    output reg request_to_send_n,
    output reg timeout_mode,
    output reg ptr_zero_pulse,
    output reg timeout_enter_pulse
);

localparam BS_IDLE = 2'h0;
localparam BS_WAIT = 2'h1;
localparam BS_SPACE = 2'h2;
localparam BS_MARK = 2'h3;

reg [1:0] state;
reg [1:0] bit_cnt;

always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
        state <= BS_IDLE;
        bit_cnt <= 2'h0;
        break_active <= 1'b0;
        tx_hold <= 1'b0;
        request_to_send_n <= 1'b1;
        timeout_mode <= 1'b0;
        ptr_zero_pulse <= 1'b0;
        timeout_enter_pulse <= 1'b0;
    end else begin
        ptr_zero_pulse <= cmd_valid && cmd_code == `UMCD_CMD_PTR_ZERO;
        timeout_enter_pulse <= cmd_valid && cmd_code == `UMCD_CMD_TMO_ON;
        if (cmd_valid) begin
            case (cmd_code)
            `UMCD_CMD_RTS_ASSERT: request_to_send_n <= 1'b0;
            `UMCD_CMD_RTS_NEGATE: request_to_send_n <= 1'b1;
            `UMCD_CMD_TMO_ON: timeout_mode <= 1'b1;
            `UMCD_CMD_TMO_OFF: timeout_mode <= 1'b0;
            default: ;
            endcase
        end
        case (state)
        BS_IDLE: begin
            if (cmd_valid && cmd_code == `UMCD_CMD_BREAK_ON && tx_enabled) begin
                state <= BS_WAIT;
                bit_cnt <= 2'h0;
            end
        end
        BS_WAIT: begin
            // Queued characters drain first, then at most two bit times
            if (cmd_valid && cmd_code == `UMCD_CMD_BREAK_OFF) begin
                state <= BS_IDLE;
            end else if (!tx_idle || tx_char_out) begin
                bit_cnt <= 2'h0;
            end else if (bit_tick) begin
                if (bit_cnt == `UMCD_BRK_DELAY_BITS - 1) begin
                    state <= BS_SPACE;
                    break_active <= 1'b1;
                    tx_hold <= 1'b1;
                end else begin
                    bit_cnt <= bit_cnt + 2'h1;
                end
            end
        end
        BS_SPACE: begin
            if (cmd_valid && cmd_code == `UMCD_CMD_BREAK_OFF) begin
                // Marking restored at once, well inside two bit times
                state <= BS_MARK;
                break_active <= 1'b0;
                bit_cnt <= 2'h0;
            end
        end
        default: begin
            // Mark hold: one full bit time before next character
            if (bit_tick) begin
                if (bit_cnt == `UMCD_MARK_HOLD_BITS) begin
                    state <= BS_IDLE;
                    tx_hold <= 1'b0;
                end else begin
                    bit_cnt <= bit_cnt + 2'h1;
                end
            end
        end
        endcase
    end
end

endmodule // umcd_channel

// File: umcd_decoder.v
`timescale 1ns/1ns
`include "umcd_regs.vh"
// ****************************************************************
// ****************************************************************
module umcd_decoder (
    // Clock and reset
    input wire clk,
    input wire rstn,
    // Command register writes
    input wire chan_a_command_wr,
    input wire [7:0] chan_a_command_reg,
    input wire chan_b_command_wr,
    input wire [7:0] chan_b_command_reg,
    // Transmitter state per channel
    input wire tx_a_enabled,
    input wire tx_a_idle,
    input wire tx_a_serial,
    input wire tx_a_char_out,
    input wire tx_b_enabled,
    input wire tx_b_idle,
    input wire tx_b_serial,
    input wire tx_b_char_out,
    input wire bit_tick_a,
    input wire bit_tick_b,
    // Receive transfers into the FIFO
    input wire rx_a_to_fifo,
    input wire rx_b_to_fifo,
    // Crystal clock activity, from a pin
    input wire crystal_clock_in,
    // Serial and modem outputs
    output reg serial_tx_out_a,
    output reg serial_tx_out_b,
    output reg request_to_send_n_a,
    output reg request_to_send_n_b,
    output reg tx_hold_a,
    output reg tx_hold_b,
    // Counter/timer controls
    output reg counter_mode_force,
    output reg counter_start_stop_block,
    output reg counter_restart,
    output reg counter_stop,
    output reg counter_ready_flag_clear,
    // Mode register pointers
    output reg [1:0] mode_reg_pointer_a,
    output reg [1:0] mode_reg_pointer_b,
    // Power control
    output reg osc_enable,
    output reg powered_down
);

// ****************************************************************
// Crystal clock detection
// ****************************************************************
wire xtal_sync;
reg xtal_prev;
wire xtal_edge;

umcd_sync u_xtal_sync (
    .clk(clk),
    .rstn(rstn),
    .async_in(crystal_clock_in),
    .sync_out(xtal_sync)
);

assign xtal_edge = xtal_sync ^ xtal_prev;

// ****************************************************************
// Command capture and decode
// ****************************************************************
wire [3:0] code_a;
wire [3:0] code_b;
wire run_a;
wire run_b;

assign code_a = chan_a_command_reg[`UMCD_CMD_HI:`UMCD_CMD_LO];
assign code_b = chan_b_command_reg[`UMCD_CMD_HI:`UMCD_CMD_LO];
// Commands need the crystal running; exit from power-down does not
assign run_a = chan_a_command_wr && !powered_down;
assign run_b = chan_b_command_wr && !powered_down;

wire brk_a;
wire brk_b;
wire hold_a;
wire hold_b;
wire rts_a;
wire rts_b;
wire tmo_a;
wire tmo_b;
wire ptr0_a;
wire ptr0_b;
wire tmo_in_a;
wire tmo_in_b;

umcd_channel u_chan_a (
    .clk(clk),
    .rstn(rstn),
    .cmd_valid(run_a),
    .cmd_code(code_a),
    .tx_enabled(tx_a_enabled),
    .tx_idle(tx_a_idle),
    .bit_tick(bit_tick_a),
    .tx_char_out(tx_a_char_out),
    .break_active(brk_a),
    .tx_hold(hold_a),
    .request_to_send_n(rts_a),
    .timeout_mode(tmo_a),
    .ptr_zero_pulse(ptr0_a),
    .timeout_enter_pulse(tmo_in_a)
);

// Same decode on channel B; power codes fall to default there
umcd_channel u_chan_b (
    .clk(clk),
    .rstn(rstn),
    .cmd_valid(run_b),
    .cmd_code(code_b),
    .tx_enabled(tx_b_enabled),
    .tx_idle(tx_b_idle),
    .bit_tick(bit_tick_b),
    .tx_char_out(tx_b_char_out),
    .break_active(brk_b),
    .tx_hold(hold_b),
    .request_to_send_n(rts_b),
    .timeout_mode(tmo_b),
    .ptr_zero_pulse(ptr0_b),
    .timeout_enter_pulse(tmo_in_b)
);

// ****************************************************************
// Outputs and shared counter/timer
// ****************************************************************
reg pd_pending;

always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
        xtal_prev <= 1'b0;
        serial_tx_out_a <= 1'b1;
        serial_tx_out_b <= 1'b1;
        request_to_send_n_a <= 1'b1;
        request_to_send_n_b <= 1'b1;
        tx_hold_a <= 1'b0;
        tx_hold_b <= 1'b0;
        counter_mode_force <= 1'b0;
        counter_start_stop_block <= 1'b0;
        counter_restart <= 1'b0;
        counter_stop <= 1'b0;
        counter_ready_flag_clear <= 1'b0;
        mode_reg_pointer_a <= `UMCD_PTR_RESET;
        mode_reg_pointer_b <= `UMCD_PTR_RESET;
        osc_enable <= 1'b1;
        powered_down <= 1'b0;
        pd_pending <= 1'b0;
    end else begin
        xtal_prev <= xtal_sync;
        serial_tx_out_a <= brk_a ? 1'b0 : tx_a_serial;
        serial_tx_out_b <= brk_b ? 1'b0 : tx_b_serial;
        request_to_send_n_a <= rts_a;
        request_to_send_n_b <= rts_b;
        tx_hold_a <= hold_a;
        tx_hold_b <= hold_b;
        // Either channel in time-out mode takes over the shared timer
        counter_mode_force <= tmo_a | tmo_b;
        counter_start_stop_block <= tmo_a | tmo_b;
        counter_restart <= (tmo_a & rx_a_to_fifo) | (tmo_b & rx_b_to_fifo);
        counter_stop <= tmo_in_a | tmo_in_b;
        counter_ready_flag_clear <= tmo_in_a | tmo_in_b;
        if (ptr0_a) begin
            mode_reg_pointer_a <= `UMCD_PTR_ZERO;
        end
        if (ptr0_b) begin
            mode_reg_pointer_b <= `UMCD_PTR_ZERO;
        end
        // Power codes act only through channel A
        if (chan_a_command_wr && code_a == `UMCD_CMD_PD_OFF) begin
            osc_enable <= 1'b1;
            powered_down <= 1'b0;
            pd_pending <= 1'b0;
        end else if (run_a && code_a == `UMCD_CMD_PD_ON) begin
            pd_pending <= 1'b1;
        end else if (pd_pending && xtal_edge) begin
            // Stop on a crystal edge so the command itself completes
            osc_enable <= 1'b0;
            powered_down <= 1'b1;
            pd_pending <= 1'b0;
        end
    end
end

endmodule // umcd_decoder

// File: umcd_far.sv
`timescale 1ns/1ns
// ****
// Transmitter and crystal model
// ****
module umcd_far (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Controls
    input wire logic osc_enable,
    input wire logic busy,
    input wire logic tx_hold,
    // Towards the decoder
    output logic crystal_clock_in,
    output logic bit_tick,
    output logic char_out,
    output wire logic tx_idle
);
    logic [2:0] div;
    assign tx_idle = !busy;
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            div <= 3'h0;
            crystal_clock_in <= 1'b0;
            bit_tick <= 1'b0;
            char_out <= 1'b0;
        end else begin
            div <= div + 3'h1;
            // A stopped oscillator leaves the pin frozen
            if (osc_enable && div[0]) begin
                crystal_clock_in <= !crystal_clock_in;
            end
            bit_tick <= div == 3'h7;
            // No new character while the line is held
            char_out <= busy && !tx_hold && div == 3'h7;
        end
    end
endmodule // umcd_far

// File: umcd_decoder_checker.sv
`timescale 1ns/1ns
`include "umcd_regs.vh"
module umcd_checker (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Commands
    input wire logic chan_a_command_wr,
    input wire logic [7:0] chan_a_command_reg,
    input wire logic chan_b_command_wr,
    input wire logic [7:0] chan_b_command_reg,
    input wire logic tx_a_enabled,
    // Results
    input wire logic serial_tx_out_a,
    input wire logic tx_hold_a,
    input wire logic request_to_send_n_a,
    input wire logic request_to_send_n_b,
    input wire logic [1:0] mode_reg_pointer_a,
    input wire logic counter_stop,
    input wire logic counter_restart,
    input wire logic counter_mode_force,
    input wire logic counter_ready_flag_clear,
    input wire logic osc_enable,
    input wire logic powered_down
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    wire [3:0] ka = chan_a_command_reg[7:4];
    wire [3:0] kb = chan_b_command_reg[7:4];
    wire wa = chan_a_command_wr && !powered_down;
    wire wb = chan_b_command_wr && !powered_down;
    a_rts_low: assert property (wa && ka == `UMCD_CMD_RTS_ASSERT |-> ##[1:3] !request_to_send_n_a)
        else $error("rts a not low");
    a_rts_high: assert property (wb && kb == `UMCD_CMD_RTS_NEGATE |-> ##[1:3] request_to_send_n_b)
        else $error("rts b not high");
    a_ptr_zero: assert property (wa && ka == `UMCD_CMD_PTR_ZERO |-> ##[1:3] mode_reg_pointer_a == 2'h0)
        else $error("pointer not zero");
    a_tmo_entry: assert property (wa && ka == `UMCD_CMD_TMO_ON |-> ##[1:4] counter_stop && counter_ready_flag_clear)
        else $error("timer not stopped");
    a_tmo_off: assert property (wa && ka == `UMCD_CMD_TMO_OFF |-> !counter_stop [*4])
        else $error("timer stopped");
    a_break_gate: assert property (wa && ka == `UMCD_CMD_BREAK_ON && !tx_a_enabled && !tx_hold_a |=> !tx_hold_a [*8])
        else $error("break taken");
    a_break_hold: assert property (!serial_tx_out_a |-> tx_hold_a)
        else $error("low without hold");
    a_pd_chan_b: assert property (wb && kb == `UMCD_CMD_PD_ON |=> !powered_down [*8])
        else $error("b powered down");
    a_pd_exit: assert property (chan_a_command_wr && ka == `UMCD_CMD_PD_OFF && powered_down |-> ##[1:3] osc_enable)
        else $error("osc not back");
    a_restart_mode: assert property (counter_restart |-> counter_mode_force)
        else $error("restart outside time-out mode");
    cover property (counter_stop);
    cover property (!serial_tx_out_a);
    cover property (powered_down);
endmodule // umcd_checker
bind umcd_decoder umcd_checker umcd_checker_inst (.clk(clk), .rstn(rstn),
    .chan_a_command_wr(chan_a_command_wr), .chan_a_command_reg(chan_a_command_reg),
    .chan_b_command_wr(chan_b_command_wr), .chan_b_command_reg(chan_b_command_reg),
    .tx_a_enabled(tx_a_enabled), .serial_tx_out_a(serial_tx_out_a), .tx_hold_a(tx_hold_a),
    .request_to_send_n_a(request_to_send_n_a), .request_to_send_n_b(request_to_send_n_b),
    .mode_reg_pointer_a(mode_reg_pointer_a), .counter_stop(counter_stop),
    .counter_restart(counter_restart), .counter_mode_force(counter_mode_force),
    .counter_ready_flag_clear(counter_ready_flag_clear), .osc_enable(osc_enable),
    .powered_down(powered_down));

// File: testbench.sv
`timescale 1ns/1ns
`include "umcd_regs.vh"
module testbench;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic wa = 1'b0, wb = 1'b0, ena = 1'b0, busy = 1'b0, rxa = 1'b0, rxb = 1'b0;
    logic [7:0] ca = 8'h00, cb = 8'h00;
    logic [11:0] e, got;
    logic [11:0] notes[$];
    int n_mismatch = 0, samples_checked = 0, cycles = 0;
    event look;
    wire sa, sb, ra, rb, ha, cmf, osc, pd, xtal, tick, cho, idle;
    wire [1:0] pa, pb;
    wire [11:0] obs = {sa, sb, ra, rb, pa, pb, osc, pd, cmf, ha};
    always #25 clk = ~clk;
    umcd_far umcd_far_inst (.clk(clk), .rstn(rstn), .osc_enable(osc), .busy(busy),
        .tx_hold(ha), .crystal_clock_in(xtal), .bit_tick(tick), .char_out(cho), .tx_idle(idle));
    umcd_decoder umcd_decoder_inst (.clk(clk), .rstn(rstn),
        .chan_a_command_wr(wa), .chan_a_command_reg(ca), .chan_b_command_wr(wb),
        .chan_b_command_reg(cb), .tx_a_enabled(ena), .tx_a_idle(idle), .tx_a_serial(1'b1),
        .tx_a_char_out(cho), .tx_b_enabled(1'b1), .tx_b_idle(1'b1), .tx_b_serial(1'b1),
        .tx_b_char_out(1'b0), .bit_tick_a(tick), .bit_tick_b(tick), .rx_a_to_fifo(rxa),
        .rx_b_to_fifo(rxb), .crystal_clock_in(xtal), .serial_tx_out_a(sa),
        .serial_tx_out_b(sb), .request_to_send_n_a(ra), .request_to_send_n_b(rb),
        .tx_hold_a(ha), .tx_hold_b(), .counter_mode_force(cmf), .counter_start_stop_block(),
        .counter_restart(), .counter_stop(), .counter_ready_flag_clear(),
        .mode_reg_pointer_a(pa), .mode_reg_pointer_b(pb), .osc_enable(osc), .powered_down(pd));
    task results;
        $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // Low nibble is random: the decoder must look at bits 7 to 4 only
    task cmd(input logic chb, input logic [3:0] code, input int gap);
        @(posedge clk);
        ca <= {code, 4'($urandom)};
        cb <= {code, 4'($urandom)};
        wa <= !chb;
        wb <= chb;
        @(posedge clk);
        wa <= 1'b0;
        wb <= 1'b0;
        repeat (gap) @(posedge clk);
    endtask
    task chk(input logic [11:0] x);
        @(negedge clk);
        notes.push_back(x);
        -> look;
    endtask
    always @(look) begin
        got = notes.pop_front();
        samples_checked++;
        if (obs !== got) begin
            n_mismatch++;
            $display("Error outputs expected %h seen %h", got, obs);
        end
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 6000) begin
            n_mismatch++;
            results;
        end
    end
    initial begin
        void'($urandom(2884));
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        e = 12'hF58;
        cmd(0, `UMCD_CMD_RTS_ASSERT, 12);
        e[9] = 1'b0;
        chk(e);
        cmd(1, `UMCD_CMD_RTS_ASSERT, 12);
        e[8] = 1'b0;
        chk(e);
        cmd(1, `UMCD_CMD_RTS_NEGATE, 12);
        e[8] = 1'b1;
        chk(e);
        cmd(0, `UMCD_CMD_PTR_ZERO, 12);
        e[7:6] = 2'h0;
        chk(e);
        cmd(1, `UMCD_CMD_PTR_ZERO, 12);
        e[5:4] = 2'h0;
        chk(e);
        cmd(0, `UMCD_CMD_UNUSED, 12);
        chk(e);
        $display("modem and pointer test done");
        for (int i = 0; i < 2; i++) begin
            cmd(i[0], `UMCD_CMD_TMO_ON, 12);
            e[1] = 1'b1;
            chk(e);
            @(posedge clk);
            rxa <= 1'b1;
            rxb <= 1'b1;
            @(posedge clk);
            rxa <= 1'b0;
            rxb <= 1'b0;
            cmd(i[0], `UMCD_CMD_TMO_OFF, 12);
            e[1] = 1'b0;
            chk(e);
        end
        $display("time-out test done");
        cmd(0, `UMCD_CMD_BREAK_ON, 30);
        chk(e);
        ena <= 1'b1;
        cmd(0, `UMCD_CMD_BREAK_ON, 30);
        e[11] = 1'b0;
        e[0] = 1'b1;
        chk(e);
        cmd(0, `UMCD_CMD_BREAK_OFF, 3);
        e[11] = 1'b1;
        chk(e);
        repeat (24) @(posedge clk);
        e[0] = 1'b0;
        chk(e);
        busy <= 1'b1;
        cmd(0, `UMCD_CMD_BREAK_ON, 40);
        chk(e);
        busy <= 1'b0;
        repeat (30) @(posedge clk);
        e[11] = 1'b0;
        e[0] = 1'b1;
        chk(e);
        cmd(0, `UMCD_CMD_BREAK_OFF, 40);
        e[11] = 1'b1;
        e[0] = 1'b0;
        chk(e);
        $display("break test done");
        ena <= 1'b0;
        cmd(1, `UMCD_CMD_PD_ON, 12);
        chk(e);
        cmd(0, `UMCD_CMD_PD_ON, 12);
        e[3:2] = 2'h1;
        chk(e);
        cmd(0, `UMCD_CMD_RTS_ASSERT, 12);
        chk(e);
        cmd(0, `UMCD_CMD_PD_OFF, 20);
        e[3:2] = 2'h2;
        chk(e);
        cmd(0, `UMCD_CMD_RTS_NEGATE, 12);
        e[9] = 1'b1;
        chk(e);
        $display("power-down test done");
        results;
    end
endmodule // testbench
